/* rtl/mbd_pkg.sv */
package mbd_pkg;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int BYTE_BITS = 8;
  localparam int CNT_BITS = 5;
  localparam logic [4:0] FALLS_PER_FRAME = 5'h10;
  localparam logic [4:0] ADDR_LAST_FALL = 5'h01;
  localparam logic [4:0] INSTR_LAST_FALL = 5'h07;
  localparam logic [4:0] DATA_FIRST_RISE = 5'h07;
  localparam logic [4:0] CNT_MAX = 5'h1f;
  localparam logic [1:0] CHIP_ADDR = 2'h0;

  // ----------------------------------------------------------------
  // answer bytes
  // ----------------------------------------------------------------
  // initial pattern of the verification byte, value arbitrary
  localparam logic [6:0] VERIF_PATTERN = 7'h2a;
  localparam logic [7:0] NO_ERR_DATA = 8'hff;

  // ----------------------------------------------------------------
  // pin synchroniser lanes
  // ----------------------------------------------------------------
  localparam int PIN_LANES = 6;
  localparam int IX_MODE = 0;
  localparam int IX_EN = 1;
  localparam int IX_OFF = 2;
  localparam int IX_SCK = 3;
  localparam int IX_SEL = 4;
  localparam int IX_SDI = 5;
  localparam logic [5:0] PIN_RESET = 6'h14;

  // ----------------------------------------------------------------
  // serial state machine
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    st_wait = 4'h1,
    st_addr = 4'h2,
    st_shift = 4'h4,
    st_ignore = 4'h8
  } mbd_state_t;

endpackage : mbd_pkg

/* rtl/mbd_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module mbd_sync #(
  parameter int WIDTH = 6,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // pins in and synchronised levels out
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);

  // first stage is only ever read by the second
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= RESET_VAL;
      pin_sync <= RESET_VAL;
    end else if (clk_en) begin
      stage1 <= pin_in;
      pin_sync <= stage1;
    end
  end

endmodule : mbd_sync

`default_nettype wire

/* rtl/mbd_top.sv */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - supply under-voltage tristates the bridge and raises the under-voltage indication.
// - mode pin low selects flag reporting, high selects serial diagnosis.
// - in flag mode any shutdown failure pulls the status flag low.
// - in flag mode enable low or bridge-off high also pulls the flag low.
// - under-voltage is not latched; recovery re-enables outputs and releases the flag.
// - in flag mode under-voltage acts as power-on reset clearing stored faults.
// - short, over-current and over-temperature faults latch, holding tristate and flag low.
// - latched fault clears on bridge-off fall, enable rise or power-on reset only.
// - select high keeps the serial output released.
// - serial port works regardless of enable pins; mode low holds it in default.
// - select high forces the serial state machine into its wait state.
// - input sampled on clock falling edges, output driven on rising edges.
// - first two bits are chip address; output released until address validated.
// - wrong chip address: input ignored, output released for the whole frame.
// - verification byte with fixed pattern and previous-error flag goes out first.
// - second received byte is ignored; only reads exist.
// - unused instruction still answers verification byte then all-ones data byte.
// - frame invalid when falling clock edges under select differ from sixteen.
// - frame erroneous when clock is high as select falls.
// - errors set the frame error flag for next frame; cleared only after sent or by mode low.
// - device answers only to chip address zero.
// - frame is verification then data byte out, instruction then unused byte in.
module mbd_top (
  // clock, reset, clock enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // control pins
  input wire logic diag_mode_select,
  input wire logic enable_in,
  input wire logic bridge_off_input,
  // fault detectors, same clock domain
  input wire logic motor_supply_uv,
  input wire logic short_supply,
  input wire logic short_ground,
  input wire logic short_load,
  input wire logic over_current,
  input wire logic over_temp,
  // bridge and status outputs
  output logic bridge_hiz,
  output logic uv_error,
  output logic status_flag_pin_o,
  output logic status_flag_pin_oe,
  // serial pins
  input wire logic sck,
  input wire logic select_low,
  input wire logic sdi,
  output logic sdo_o,
  output logic sdo_oe,
  // instruction decoder side
  output logic instr_strobe,
  output logic [4:0] instr_code,
  input wire logic instr_used,
  input wire logic [7:0] resp_data,
  output logic frame_error_flag
);

  // ----------------------------------------------------------------
  // pin synchronisation and edges
  // ----------------------------------------------------------------
  logic [mbd_pkg::PIN_LANES-1:0] pin_s;
  logic mode_spi;
  logic en_s;
  logic off_s;
  logic sck_s;
  logic sel_s;
  logic sdi_s;
  logic en_q;
  logic off_q;
  logic sck_q;
  logic sel_q;

  mbd_sync #(
    .WIDTH(mbd_pkg::PIN_LANES),
    .RESET_VAL(mbd_pkg::PIN_RESET)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pin_in({sdi, select_low, sck, bridge_off_input, enable_in, diag_mode_select}),
    .pin_sync(pin_s)
  );

  assign mode_spi = pin_s[mbd_pkg::IX_MODE];
  assign en_s = pin_s[mbd_pkg::IX_EN];
  assign off_s = pin_s[mbd_pkg::IX_OFF];
  assign sck_s = pin_s[mbd_pkg::IX_SCK];
  assign sel_s = pin_s[mbd_pkg::IX_SEL];
  assign sdi_s = pin_s[mbd_pkg::IX_SDI];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 1'b0;
      off_q <= 1'b1;
      sck_q <= 1'b0;
      sel_q <= 1'b1;
    end else if (clk_en) begin
      en_q <= en_s;
      off_q <= off_s;
      sck_q <= sck_s;
      sel_q <= sel_s;
    end
  end

  logic sck_fall;
  logic sck_rise;
  logic sel_fall;
  logic sel_rise;
  assign sck_fall = sck_q & ~sck_s;
  assign sck_rise = ~sck_q & sck_s;
  assign sel_fall = sel_q & ~sel_s;
  assign sel_rise = ~sel_q & sel_s;

  // ----------------------------------------------------------------
  // bridge protection and status flag
  // ----------------------------------------------------------------
  logic latched_fault;
  logic live_fault;
  logic clear_evt;
  logic por;
  logic off_cond;

  // fault inputs come from logic on mclk, so no synchroniser
  assign live_fault = short_supply | short_ground | short_load | over_current | over_temp;
  assign clear_evt = (off_q & ~off_s) | (~en_q & en_s);
  assign por = motor_supply_uv & ~mode_spi;
  assign off_cond = motor_supply_uv | live_fault | latched_fault | ~en_s | off_s;

  // power-on reset beats a new fault: the part loses its supply then
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      latched_fault <= 1'b0;
    end else if (clk_en) begin
      if (por) begin
        latched_fault <= 1'b0;
      end else if (live_fault) begin
        latched_fault <= 1'b1;
      end else if (clear_evt) begin
        latched_fault <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bridge_hiz <= 1'b1;
      uv_error <= 1'b0;
      status_flag_pin_o <= 1'b0;
      status_flag_pin_oe <= 1'b0;
    end else if (clk_en) begin
      bridge_hiz <= off_cond;
      uv_error <= motor_supply_uv;
      status_flag_pin_o <= 1'b0;
      status_flag_pin_oe <= ~mode_spi & off_cond;
    end
  end

  // ----------------------------------------------------------------
  // serial state machine
  // ----------------------------------------------------------------
  mbd_pkg::mbd_state_t state;
  logic spi_hold;
  logic [mbd_pkg::CNT_BITS-1:0] fall_cnt;
  logic [mbd_pkg::CNT_BITS-1:0] rise_cnt;
  logic [7:0] rx;
  logic [7:0] tx;
  logic sck_hi_err;
  logic instr_bad;
  logic data_turn;
  logic flag_clr;
  logic frame_end_err;

  // enable and bridge-off play no part here
  assign spi_hold = ~mode_spi | sel_s;
  assign data_turn = (state == mbd_pkg::st_shift) && sck_rise
    && (rise_cnt == mbd_pkg::DATA_FIRST_RISE);
  assign flag_clr = data_turn;
  assign frame_end_err = sel_rise && (state == mbd_pkg::st_shift)
    && ((fall_cnt != mbd_pkg::FALLS_PER_FRAME) || sck_hi_err || instr_bad);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= mbd_pkg::st_wait;
    end else if (clk_en) begin
      if (spi_hold) begin
        state <= mbd_pkg::st_wait;
      end else begin
        case (state)
          mbd_pkg::st_wait: begin
            if (sel_fall) begin
              state <= mbd_pkg::st_addr;
            end
          end
          mbd_pkg::st_addr: begin
            if (sck_fall && fall_cnt == mbd_pkg::ADDR_LAST_FALL) begin
              if ({rx[0], sdi_s} == mbd_pkg::CHIP_ADDR) begin
                state <= mbd_pkg::st_shift;
              end else begin
                state <= mbd_pkg::st_ignore;
              end
            end
          end
          mbd_pkg::st_shift: state <= mbd_pkg::st_shift;
          mbd_pkg::st_ignore: state <= mbd_pkg::st_ignore;
          default: state <= mbd_pkg::st_wait;
        endcase
      end
    end
  end

  // counters saturate so a runaway clock cannot wrap back to sixteen
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fall_cnt <= '0;
      rise_cnt <= '0;
    end else if (clk_en) begin
      if (spi_hold || sel_fall) begin
        fall_cnt <= '0;
        rise_cnt <= '0;
      end else begin
        if (sck_fall && fall_cnt != mbd_pkg::CNT_MAX) begin
          fall_cnt <= fall_cnt + 5'h01;
        end
        if (sck_rise && rise_cnt != mbd_pkg::CNT_MAX) begin
          rise_cnt <= rise_cnt + 5'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // receive side
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx <= '0;
      instr_strobe <= 1'b0;
      instr_code <= '0;
    end else if (clk_en) begin
      instr_strobe <= 1'b0;
      if (!spi_hold && sck_fall) begin
        rx <= {rx[6:0], sdi_s};
      end
      // only the eighth edge of a matched frame hands on an instruction
      if (state == mbd_pkg::st_shift && sck_fall && fall_cnt == mbd_pkg::INSTR_LAST_FALL) begin
        instr_strobe <= 1'b1;
        instr_code <= rx[4:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit side
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx <= '0;
      sdo_o <= 1'b0;
      sdo_oe <= 1'b0;
    end else if (clk_en) begin
      sdo_oe <= ~spi_hold && (state == mbd_pkg::st_shift);
      if (spi_hold) begin
        tx <= '0;
        sdo_o <= 1'b0;
      end else if (sel_fall) begin
        // nothing goes out before the first rise, as the master samples on falls
        tx <= {mbd_pkg::VERIF_PATTERN, frame_error_flag};
      end else if (data_turn) begin
        // eighth rise sends the error flag and lines up the data byte behind it
        sdo_o <= tx[7];
        if (instr_used) begin
          tx <= resp_data;
        end else begin
          tx <= mbd_pkg::NO_ERR_DATA;
        end
      end else if (sck_rise) begin
        tx <= {tx[6:0], 1'b0};
        sdo_o <= tx[7];
      end
    end
  end

  // ----------------------------------------------------------------
  // transfer error tracking
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sck_hi_err <= 1'b0;
      instr_bad <= 1'b0;
    end else if (clk_en) begin
      if (sel_fall) begin
        sck_hi_err <= sck_s;
        instr_bad <= 1'b0;
      end else if (data_turn) begin
        instr_bad <= ~instr_used;
      end
    end
  end

  // a new error wins over the clear in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      frame_error_flag <= 1'b0;
    end else if (clk_en) begin
      if (!mode_spi) begin
        frame_error_flag <= 1'b0;
      end else if (frame_end_err) begin
        frame_error_flag <= 1'b1;
      end else if (flag_clr) begin
        frame_error_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_uv_tristate: assert property (clk_en && motor_supply_uv |=> bridge_hiz && uv_error)
    else $error("under-voltage did not tristate the bridge");
  a_uv_recovers: assert property (clk_en && !off_cond |=> !bridge_hiz && !status_flag_pin_oe)
    else $error("bridge stayed off with no cause");
  a_flag_pulls: assert property (clk_en && !mode_spi && (live_fault || !en_s || off_s)
    |=> status_flag_pin_oe && !status_flag_pin_o)
    else $error("status flag not pulled low on shutdown");
  a_flag_spi_off: assert property (clk_en && mode_spi |=> !status_flag_pin_oe)
    else $error("status flag driven in serial mode");
  a_por_clears: assert property (clk_en && por |=> !latched_fault)
    else $error("power-on reset left a stored fault");
  a_fault_latch: assert property (clk_en && live_fault && !por ##1 clk_en && !por && !clear_evt
    |=> latched_fault && bridge_hiz)
    else $error("fault not held after it vanished");
  a_sel_idle: assert property (clk_en && sel_s |=> !sdo_oe && state == mbd_pkg::st_wait)
    else $error("deselected port not idle");
  a_ignore_quiet: assert property (state == mbd_pkg::st_ignore |-> !sdo_oe)
    else $error("output driven for foreign address");
  a_count_err: assert property (clk_en && mode_spi && sel_rise && state == mbd_pkg::st_shift
    && fall_cnt != mbd_pkg::FALLS_PER_FRAME |=> frame_error_flag)
    else $error("bad edge count not flagged");
  a_flag_sticky: assert property (frame_error_flag && clk_en && mode_spi && !flag_clr
    |=> frame_error_flag)
    else $error("frame error flag lost before sent");

  c_good_frame: cover property (sel_rise && state == mbd_pkg::st_shift && !frame_end_err);
  c_bad_frame: cover property (frame_end_err);
  c_foreign: cover property (state == mbd_pkg::st_ignore);
  c_fault_clear: cover property (latched_fault ##1 !latched_fault);

endmodule : mbd_top

`default_nettype wire

/* tb/mbd_spi_master.sv */
`timescale 1ns/1ps
`default_nettype none

module mbd_spi_master (
  // serial pins toward the device
  output logic sck,
  output logic select_low,
  output logic sdi,
  input wire logic sdo_o,
  input wire logic sdo_oe
);
  // ----------------------------------------------------------------
  // serial master
  // ----------------------------------------------------------------
  // released line reads as z so the bench sees tristate itself
  wire sdo_line = sdo_oe ? sdo_o : 1'bz;

  initial begin
    sck = 1'b0;
    select_low = 1'b1;
    sdi = 1'b0;
  end

  // 80 ns clock stays well below the top serial rate; idle low between frames
  task automatic xfer(input logic [15:0] tx, input int falls, input bit sck_hi,
                      output logic [15:0] rx);
    rx = 16'hzzzz;
    sck = sck_hi;
    #40;
    select_low = 1'b0;
    #40;
    for (int i = 0; i < falls; i++) begin
      sck = 1'b1;
      sdi = tx[15 - (i % 16)];
      #40;
      sck = 1'b0;
      if (i < 16) rx[15 - i] = sdo_line;
      #40;
    end
    select_low = 1'b1;
    // no stale level after release
    sdi = ~sdi;
    #80;
  endtask : xfer

endmodule : mbd_spi_master

`default_nettype wire

/* tb/mbd_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module mbd_top_tb;
  // ----------------------------------------------------------------
  // stimulus and wiring
  // ----------------------------------------------------------------
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic mode = 1'b0;
  logic en = 1'b1;
  logic off = 1'b0;
  logic uv = 1'b0;
  logic [4:0] flt = 5'h00;
  logic used = 1'b1;
  logic [7:0] resp = 8'h00;
  logic sck, sel_n, sdi, sdo_o, sdo_oe, hiz, uv_err, sf_o, sf_oe, strobe, ferr;
  logic [4:0] code;
  int n_strobes = 0;
  int n_errors = 0;
  int samples_checked = 0;
  // open-drain flag with its external pull-up
  wire sf_line = sf_oe ? sf_o : 1'b1;

  always #4 mclk = ~mclk;
  always @(posedge mclk) if (strobe) n_strobes <= n_strobes + 1;

  mbd_top dut (.mclk(mclk), .rst_n(rst_n), .clk_en(1'b1), .diag_mode_select(mode),
    .enable_in(en), .bridge_off_input(off), .motor_supply_uv(uv),
    .short_supply(flt[0]), .short_ground(flt[1]), .short_load(flt[2]),
    .over_current(flt[3]), .over_temp(flt[4]), .bridge_hiz(hiz), .uv_error(uv_err),
    .status_flag_pin_o(sf_o), .status_flag_pin_oe(sf_oe), .sck(sck), .select_low(sel_n),
    .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .instr_strobe(strobe), .instr_code(code),
    .instr_used(used), .resp_data(resp), .frame_error_flag(ferr));

  mbd_spi_master master (.sck(sck), .select_low(sel_n), .sdi(sdi), .sdo_o(sdo_o),
    .sdo_oe(sdo_oe));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic conclude();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_disable();
    en = 1'b0;
    step(5);
    chk_bit(sf_line, 1'b0);
    en = 1'b1;
    off = 1'b1;
    step(5);
    chk_bit(sf_line, 1'b0);
    off = 1'b0;
    step(5);
    chk_bit(sf_line, 1'b1);
  endtask : test_disable

  // odd faults clear by bridge-off fall, even ones by enable rise
  task automatic test_latch();
    for (int k = 0; k < 5; k++) begin
      flt = 5'h01 << k;
      step(2);
      chk_bit(sf_line, 1'b0);
      flt = 5'h00;
      step(6);
      chk_bit(hiz, 1'b1);
      chk_bit(sf_line, 1'b0);
      off = k[0];
      en = k[0];
      step(6);
      off = 1'b0;
      en = 1'b1;
      step(6);
      chk_bit(hiz, 1'b0);
      chk_bit(sf_line, 1'b1);
    end
  endtask : test_latch

  task automatic test_uv();
    flt = 5'h04;
    step(2);
    flt = 5'h00;
    uv = 1'b1;
    step(2);
    chk_bit(uv_err, 1'b1);
    chk_bit(hiz, 1'b1);
    chk_bit(sf_line, 1'b0);
    uv = 1'b0;
    step(3);
    chk_bit(hiz, 1'b0);
    chk_bit(sf_line, 1'b1);
  endtask : test_uv

  task automatic frame(input logic [1:0] a, input logic [4:0] c, input logic u,
                       input logic [7:0] d, input logic fl);
    logic [15:0] rx;
    logic [15:0] want;
    logic hit;
    int s0;
    hit = (a == mbd_pkg::CHIP_ADDR);
    used = u;
    resp = d;
    s0 = n_strobes;
    // the first two bits fall while the output is still released
    want = {2'bzz, mbd_pkg::VERIF_PATTERN[4:0], fl, u ? d : mbd_pkg::NO_ERR_DATA};
    master.xfer({a, c, 1'b0, 8'h5a}, 16, 1'b0, rx);
    chk_word(rx, hit ? want : 16'hzzzz);
    chk_word(16'(n_strobes - s0), {15'h0000, hit});
    if (hit) chk_word({11'h000, code}, {11'h000, c});
  endtask : frame

  task automatic test_serial();
    logic [15:0] rx;
    int nf[3] = '{15, 17, 16};
    mode = 1'b1;
    en = 1'b0;
    step(5);
    chk_bit(sf_line, 1'b1);
    frame(2'h0, 5'h03, 1'b1, 8'h5c, 1'b0);
    en = 1'b1;
    frame(2'h0, 5'h1d, 1'b0, 8'h00, 1'b0);
    step(2);
    chk_bit(ferr, 1'b1);
    frame(2'h0, 5'h03, 1'b1, 8'ha3, 1'b1);
    step(2);
    chk_bit(ferr, 1'b0);
    for (int i = 0; i < 3; i++) begin
      master.xfer(16'h065a, nf[i], i == 2, rx);
      step(4);
      chk_bit(ferr, 1'b1);
      frame(2'h0, 5'h07, 1'b1, 8'h3c, 1'b1);
    end
    frame(2'h1, 5'h03, 1'b1, 8'h11, 1'b0);
    step(2);
    chk_bit(ferr, 1'b0);
    master.xfer(16'h065a, 15, 1'b0, rx);
    chk_bit(ferr, 1'b1);
    mode = 1'b0;
    step(6);
    chk_bit(ferr, 1'b0);
    mode = 1'b1;
    step(4);
    frame(2'h0, 5'h03, 1'b1, 8'h96, 1'b0);
  endtask : test_serial

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    #1;
    chk_bit(hiz, 1'b1);
    rst_n = 1'b1;
    step(4);
    test_disable();
    test_latch();
    test_uv();
    test_serial();
    conclude();
  end

  // the whole run needs some 19 us; a hang is cut off well beyond that
  initial begin
    #200000;
    n_errors++;
    conclude();
  end

endmodule : mbd_top_tb

`default_nettype wire
